//--- pkg/tsa_defs.vh
// Constants for the temperature sensor alarm block
`ifndef TSA_DEFS_VH
`define TSA_DEFS_VH
// ****************************************************************
// Register select codes
// ****************************************************************
`define TSA_REG_TEMP      2'h0
`define TSA_REG_CONFIG    2'h1
`define TSA_REG_CLEAR     2'h2
`define TSA_REG_SET       2'h3
`define TSA_PTR_RESET     2'h0
// ****************************************************************
// Configuration fields
// ****************************************************************
`define TSA_CFG_SHUTDOWN  0
`define TSA_CFG_INTMODE   1
`define TSA_CFG_POLARITY  2
`define TSA_CFG_FQ_LO     3
`define TSA_CFG_FQ_HI     4
`define TSA_CFG_RESET     8'h00
`define TSA_CFG_MASK      8'h1f
// ****************************************************************
// Thresholds, address and fault counts
// ****************************************************************
`define TSA_SET_RESET     9'h0a0
`define TSA_CLEAR_RESET   9'h096
`define TSA_ADDR_HI       4'h9
`define TSA_FQ_1          3'h1
`define TSA_FQ_2          3'h2
`define TSA_FQ_4          3'h4
`define TSA_FQ_6          3'h6
`endif

//--- src/tsa_i2c_slave.v
// Serial slave port with pointer based register access
`timescale 1ns/1ns
`include "tsa_defs.vh"
module tsa_i2c_slave
(
  input  wire       clk,
  input  wire       reset_n,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  input  wire [2:0] address_select_pins,
  output reg  [1:0] register_select_field,
  output reg  [7:0] wr_data_q,
  output reg        wr_strobe_q,
  output reg  [2:0] wr_index_q,
  input  wire [15:0] rd_word,
  output reg        rd_done_q
);
  // ****************************************************************
  // Synchronisers and edge detection
  // ****************************************************************
  reg [1:0] scl_sync_q;
  reg [1:0] sda_sync_q;
  reg       scl_last_q;
  reg       sda_last_q;
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_last_q <= 1'b1;
      sda_last_q <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_last_q <= scl_sync_q[1];
      sda_last_q <= sda_sync_q[1];
    end
  end
  wire scl = scl_sync_q[1];
  wire sda = sda_sync_q[1];
  wire scl_rise = scl & ~scl_last_q;
  wire scl_fall = ~scl & scl_last_q;
  wire start_c = scl & scl_last_q & sda_last_q & ~sda;
  wire stop_c  = scl & scl_last_q & ~sda_last_q & sda;
  // ****************************************************************
  // Byte engine
  // ****************************************************************
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_WRB  = 3'h2;
  localparam ST_RDB  = 3'h3;
  localparam ST_RACK = 3'h4;
  reg [2:0]  state_q;
  reg [3:0]  bit_q;
  reg [7:0]  shift_q;
  reg        ack_q;
  reg        drive_q;
  reg        read_seen_q;
  reg [15:0] tx_q;
  assign sda_out = 1'b0;
  assign sda_oe  = drive_q;
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      ack_q <= 1'b0;
      drive_q <= 1'b0;
      read_seen_q <= 1'b0;
      tx_q <= 16'h0000;
      register_select_field <= `TSA_PTR_RESET; // RULE8
      wr_data_q <= 8'h00;
      wr_strobe_q <= 1'b0;
      wr_index_q <= 3'h0;
      rd_done_q <= 1'b0;
    end
    else
    begin
      wr_strobe_q <= 1'b0;
      rd_done_q <= 1'b0;
      if (stop_c)
      begin
        // Stop frees a held data line and ends any read
        state_q <= ST_IDLE; // RULE17
        drive_q <= 1'b0;
        ack_q <= 1'b0;
        rd_done_q <= read_seen_q; // RULE6
        read_seen_q <= 1'b0;
      end
      else if (start_c)
      begin
        state_q <= ST_ADDR;
        bit_q <= 4'h0;
        drive_q <= 1'b0;
        ack_q <= 1'b0;
        rd_done_q <= read_seen_q;
        read_seen_q <= 1'b0;
      end
      else if (scl_rise && !ack_q && (state_q == ST_ADDR || state_q == ST_WRB))
      begin
        shift_q <= {shift_q[6:0], sda};
        bit_q <= bit_q + 4'h1;
      end
      else if (scl_rise && state_q == ST_RACK)
      begin
        // Nack ends the read, ack carries on with the next byte
        if (sda)
          state_q <= ST_IDLE; // RULE15
        else
        begin
          // Master ack: the next fall launches the following byte
          state_q <= ST_RDB;
          ack_q <= 1'b1;
        end
        bit_q <= 4'h0;
      end
      else if (scl_fall)
      begin
        if (ack_q)
        begin
          ack_q <= 1'b0;
          drive_q <= 1'b0;
          bit_q <= 4'h0;
          if (state_q == ST_RDB)
            drive_q <= ~tx_q[15]; // RULE14
        end
        else if (state_q == ST_ADDR && bit_q == 4'h8)
        begin
          if (shift_q[7:1] == {`TSA_ADDR_HI, address_select_pins}) // RULE20
          begin
            ack_q <= 1'b1;
            drive_q <= 1'b1;
            if (shift_q[0])
            begin
              // No pointer byte needed when pointer is already right
              state_q <= ST_RDB; // RULE12
              tx_q <= rd_word;
              read_seen_q <= 1'b1;
            end
            else
            begin
              state_q <= ST_WRB; // RULE10
              wr_index_q <= 3'h0;
            end
          end
          else
            state_q <= ST_IDLE;
        end
        else if (state_q == ST_WRB && bit_q == 4'h8)
        begin
          ack_q <= 1'b1;
          drive_q <= 1'b1;
          if (wr_index_q == 3'h0)
            register_select_field <= shift_q[1:0]; // RULE18
          else
          begin
            wr_data_q <= shift_q;
            wr_strobe_q <= 1'b1; // RULE11
          end
          if (wr_index_q != 3'h7)
            wr_index_q <= wr_index_q + 3'h1;
        end
        else if (state_q == ST_RDB)
        begin
          if (bit_q == 4'h7)
          begin
            // Release for the master acknowledge bit
            state_q <= ST_RACK; // RULE16
            drive_q <= 1'b0;
            tx_q <= {tx_q[14:0], 1'b0};
          end
          else
          begin
            tx_q <= {tx_q[14:0], 1'b0};
            drive_q <= ~tx_q[14];
            bit_q <= bit_q + 4'h1;
          end
        end
      end
    end
  end
endmodule

//--- src/tsa_top.v
// Temperature sensor digital core with alarm logic and serial slave
//
// Overview of operation
// RULE1: Temperature and thresholds are 9-bit two's complement, half degree steps.
// RULE2: Serial port and writable registers stay usable during shutdown.
// RULE3: Shutdown in interrupt mode clears the alarm; comparator mode unspecified.
// RULE4: Alarm sets only after programmed consecutive faults; non-fault restarts count.
// RULE5: Trigger conditions identical in comparator and interrupt modes.
// RULE6: Interrupt mode alarm holds until master completes any register read.
// RULE7: Alarm defaults active low; polarity bit inverts the level.
// RULE8: Pointer resets to zero and holds until a new pointer byte.
// RULE9: Temperature register is read-only; writes leave it unchanged.
// RULE10: Master writes address byte then pointer byte before data.
// RULE11: Configuration takes one data byte; thresholds take two.
// RULE12: Read with pointer set is address byte then data bytes.
// RULE13: Other register read uses pointer write, repeated start, address read.
// RULE14: Multi-byte registers go out high byte first, high bit first.
// RULE15: Ack or nack after last read byte accepted; nack ends read.
// RULE16: Held data line released within nine further clocks.
// RULE17: Stop condition resets the serial interface state.
// RULE18: Pointer low bits select temperature, config, clear, set registers.
// RULE19: Master writes zeros to pointer bits two to seven.
// RULE20: Slave address is 1001 followed by the three select pins.
// RULE21: Fault field codes one, two, four or six consecutive faults.
// RULE22: Config bits select shutdown, interrupt mode, active-high; reset zero.
// RULE23: Sixteen-bit registers carry the value in bits fifteen to seven.
// RULE24: Comparator sets above set level, clears below clear level.
// RULE25: Interrupt mode events alternate between over-set and under-clear.
`timescale 1ns/1ns
`include "tsa_defs.vh"
module tsa_top
(
  input  wire       clk,
  input  wire       reset_n,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  input  wire [2:0] address_select_pins,
  input  wire [8:0] conv_temp,
  input  wire       conv_valid,
  output wire       overtemp_alarm_output,
  output wire       overtemp_alarm_oe,
  output wire       shutdown_active
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function signed_gt;
    input [8:0] a;
    input [8:0] b;
    begin
      signed_gt = ($signed(a) > $signed(b)); // RULE1
    end
  endfunction
  function [2:0] fault_need;
    input [1:0] code;
    begin
      case (code) // RULE21
        2'h0: fault_need = `TSA_FQ_1;
        2'h1: fault_need = `TSA_FQ_2;
        2'h2: fault_need = `TSA_FQ_4;
        default: fault_need = `TSA_FQ_6;
      endcase
    end
  endfunction
  // ****************************************************************
  // Address pins
  // ****************************************************************
  // The straps are static, but they are still pins and may move at any time
  reg  [2:0]  addr_meta_q;
  reg  [2:0]  addr_sync_q;
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      addr_meta_q <= 3'h0;
      addr_sync_q <= 3'h0;
    end
    else
    begin
      addr_meta_q <= address_select_pins;
      addr_sync_q <= addr_meta_q;
    end
  end
  // ****************************************************************
  // Serial slave
  // ****************************************************************
  wire [1:0]  register_select_field;
  wire [7:0]  wr_data;
  wire        wr_strobe;
  wire [2:0]  wr_index;
  wire        rd_done;
  reg  [15:0] rd_word;
  tsa_i2c_slave u_slave
  (
    .clk                   (clk),
    .reset_n               (reset_n),
    .scl_in                (scl_in),
    .sda_in                (sda_in),
    .sda_out               (sda_out),
    .sda_oe                (sda_oe),
    .address_select_pins   (addr_sync_q),
    .register_select_field (register_select_field),
    .wr_data_q             (wr_data),
    .wr_strobe_q           (wr_strobe),
    .wr_index_q            (wr_index),
    .rd_word               (rd_word),
    .rd_done_q             (rd_done)
  );
  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [8:0] temp_q;
  reg [7:0] config_q;
  reg [8:0] alarm_set_level_q;
  reg [8:0] alarm_clear_level_q;
  reg [7:0] hold_q;
  wire shut   = config_q[`TSA_CFG_SHUTDOWN];
  wire intm   = config_q[`TSA_CFG_INTMODE];
  wire pol_hi = config_q[`TSA_CFG_POLARITY];
  assign shutdown_active = shut;
  always @*
  begin
    case (register_select_field)
      `TSA_REG_TEMP:   rd_word = {temp_q, 7'h00}; // RULE23
      `TSA_REG_CONFIG: rd_word = {config_q, config_q};
      `TSA_REG_CLEAR:  rd_word = {alarm_clear_level_q, 7'h00};
      default:         rd_word = {alarm_set_level_q, 7'h00};
    endcase
  end
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      config_q <= `TSA_CFG_RESET; // RULE22
      alarm_set_level_q <= `TSA_SET_RESET;
      alarm_clear_level_q <= `TSA_CLEAR_RESET;
      hold_q <= 8'h00;
    end
    else if (wr_strobe)
    begin
      // Writes are honoured regardless of shutdown
      // The byte index has already stepped on when its strobe arrives
      case (register_select_field) // RULE2
        `TSA_REG_CONFIG:
          if (wr_index == 3'h2)
            config_q <= wr_data & `TSA_CFG_MASK; // RULE11
        `TSA_REG_CLEAR:
          if (wr_index == 3'h2)
            hold_q <= wr_data;
          else if (wr_index == 3'h3)
            alarm_clear_level_q <= {hold_q, wr_data[7]};
        `TSA_REG_SET:
          if (wr_index == 3'h2)
            hold_q <= wr_data;
          else if (wr_index == 3'h3)
            alarm_set_level_q <= {hold_q, wr_data[7]};
        default:
          hold_q <= hold_q; // RULE9
      endcase
    end
  end
  // ****************************************************************
  // Conversion result and fault queue
  // ****************************************************************
  reg [2:0] over_cnt_q;
  reg [2:0] under_cnt_q;
  reg       cmp_state_q;
  reg       int_arm_high_q;
  reg       alarm_q;
  wire      over  = signed_gt(conv_temp, alarm_set_level_q);
  wire      under = signed_gt(alarm_clear_level_q, conv_temp);
  wire [2:0] need = fault_need(config_q[`TSA_CFG_FQ_HI:`TSA_CFG_FQ_LO]);
  wire      over_q_hit  = over  && (over_cnt_q  + 3'h1 >= need);
  wire      under_q_hit = under && (under_cnt_q + 3'h1 >= need);
  // A pending alarm swallows further events until a read frees it
  wire      int_open    = ~alarm_q | rd_done;
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      temp_q <= 9'h000;
      over_cnt_q <= 3'h0;
      under_cnt_q <= 3'h0;
      cmp_state_q <= 1'b0;
      int_arm_high_q <= 1'b1;
      alarm_q <= 1'b0;
    end
    else
    begin
      // Conversions pause in shutdown, so the queue also stands still
      if (conv_valid && !shut)
      begin
        temp_q <= conv_temp;
        over_cnt_q  <= over  ? (over_q_hit  ? need : over_cnt_q + 3'h1) : 3'h0; // RULE4
        under_cnt_q <= under ? (under_q_hit ? need : under_cnt_q + 3'h1) : 3'h0;
        if (over_q_hit) // RULE24
          cmp_state_q <= 1'b1;
        else if (under_q_hit)
          cmp_state_q <= 1'b0;
      end
      if (intm)
      begin
        // Event set beats a read clear in the same cycle
        if (conv_valid && !shut && int_open && int_arm_high_q && over_q_hit) // RULE5
        begin
          alarm_q <= 1'b1;
          int_arm_high_q <= 1'b0; // RULE25
        end
        else if (conv_valid && !shut && int_open && !int_arm_high_q && under_q_hit)
        begin
          alarm_q <= 1'b1;
          int_arm_high_q <= 1'b1;
        end
        else if (rd_done || shut) // RULE6
          alarm_q <= 1'b0; // RULE3
      end
      else
      begin
        // Comparator mode keeps its state through shutdown
        alarm_q <= (conv_valid && !shut) ? (over_q_hit | (cmp_state_q & ~under_q_hit))
                                         : cmp_state_q;
        int_arm_high_q <= 1'b1;
      end
    end
  end
  // Open drain: drive low when the output level should be low
  assign overtemp_alarm_output = 1'b0;
  assign overtemp_alarm_oe = pol_hi ? ~alarm_q : alarm_q; // RULE7
endmodule

//--- dv/tsa_chk_sva.sv
// Port checker for the temperature sensor alarm block
`timescale 1ns/1ns
module tsa_chk
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic conv_valid,
  input wire logic overtemp_alarm_output,
  input wire logic overtemp_alarm_oe,
  input wire logic shutdown_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [1:0] bus_q;
  logic [7:0] idle_q;
  logic [7:0] hold_q;
  // ****
  // Bus idle and line hold counters
  // ****
  always @(posedge clk)
  begin
    bus_q <= {scl_in, sda_in};
    if (!reset_n || bus_q != {scl_in, sda_in})
      idle_q <= 8'h00;
    else if (idle_q != 8'hff)
      idle_q <= idle_q + 8'h01;
    hold_q <= sda_oe ? hold_q + 8'h01 : 8'h00;
  end
  property p_od; !sda_out && !overtemp_alarm_output; endproperty
  a_od: assert property (p_od) else $error("drive value not zero");
  property p_rst; disable iff (1'b0) !reset_n |=> !sda_oe && !overtemp_alarm_oe && !shutdown_active; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared in reset");
  property p_sda_low; $changed(sda_oe) |-> !scl_in && !$past(scl_in); endproperty
  a_sda_low: assert property (p_sda_low) else $error("data moved with clock high");
  property p_hold; hold_q < 8'h50; endproperty
  a_hold: assert property (p_hold) else $error("data line held too long");
  // A quiet bus rules out read clears and config writes as a cause
  property p_alarm_idle; idle_q >= 8'h0a && $changed(overtemp_alarm_oe) |-> $past(conv_valid); endproperty
  a_alarm_idle: assert property (p_alarm_idle) else $error("alarm moved without conversion");
  property p_sd_idle; idle_q >= 8'h0a |-> $stable(shutdown_active); endproperty
  a_sd_idle: assert property (p_sd_idle) else $error("shutdown moved without bus");
  property p_sd_conv; idle_q >= 8'h0a && shutdown_active && conv_valid |=> $stable(overtemp_alarm_oe); endproperty
  a_sd_conv: assert property (p_sd_conv) else $error("alarm moved in shutdown");
  property p_release; idle_q >= 8'h0a |-> !sda_oe; endproperty
  a_release: assert property (p_release) else $error("data held on idle bus");
endmodule
bind tsa_top tsa_chk i_tsa_chk (.clk, .reset_n, .scl_in, .sda_in, .sda_out, .sda_oe, .conv_valid,
  .overtemp_alarm_output, .overtemp_alarm_oe, .shutdown_active);

//--- dv/tsa_i2c_master.sv
// Bus master model for the serial port of the block
`timescale 1ns/1ns
module tsa_i2c_master
(
  input  wire logic clk,
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  logic r;
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Low phase of five cycles lets slave data settle before the rise
  task automatic rise(input logic d);
    w(1);
    sda_drv = d;
    w(4);
    scl = 1'b1;
    w(2);
  endtask
  task automatic bitx(input logic b, output logic q);
    rise(!b);
    q = sda;
    w(1);
    scl = 1'b0;
  endtask
  // From a low clock this gives a repeated start
  task automatic start;
    if (!scl)
      rise(1'b0);
    sda_drv = 1'b1;
    w(3);
    scl = 1'b0;
  endtask
  task automatic stop;
    rise(1'b1);
    sda_drv = 1'b0;
    w(4);
  endtask
  task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(a, k);
  endtask
  // Clocks out a held data line, then the stop clears the slave
  task automatic recover(output int n);
    n = 0;
    do
    begin
      bitx(1'b1, r);
      n++;
    end
    while (!r && n < 12);
    stop();
  endtask
endmodule

//--- dv/tb_top.sv
// Self-checking bench for the temperature sensor alarm block
`timescale 1ns/1ns
`include "tsa_defs.vh"
module tb_top;
  localparam logic [6:0] dev_addr = {`TSA_ADDR_HI, 3'h5};
  logic        clk;
  logic        reset_n;
  logic [8:0]  conv_temp;
  logic        conv_valid;
  logic        ack;
  logic [15:0] rdv;
  wire         scl;
  wire         m_drv;
  wire         sda_oe;
  wire         alarm_oe;
  wire         shutdown_active;
  wire         sda = !(m_drv || sda_oe);
  int          n_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  tsa_top i_tsa_top (.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .address_select_pins(3'h5), .conv_temp(conv_temp),
    .conv_valid(conv_valid), .overtemp_alarm_output(), .overtemp_alarm_oe(alarm_oe),
    .shutdown_active(shutdown_active));
  tsa_i2c_master i_tsa_i2c_master (.clk(clk), .scl(scl), .sda_drv(m_drv), .sda(sda));
  task automatic results;
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic xw(input logic [7:0] d, input logic ea);
    logic [7:0] q;
    i_tsa_i2c_master.xbyte(d, 1'b1, q, ack);
    chk(16'(ack), 16'(ea));
  endtask
  task automatic wr(input logic [1:0] p, input int n, input logic [15:0] d);
    i_tsa_i2c_master.start();
    xw({dev_addr, 1'b0}, 1'b0);
    xw({6'h00, p}, 1'b0);
    for (int i = 0; i < n; i++)
      xw(i ? d[7:0] : d[15:8], 1'b0);
    i_tsa_i2c_master.stop();
  endtask
  task automatic rc(input int p, input int n, input logic [15:0] e);
    logic [7:0] q;
    rdv = 16'h0000;
    i_tsa_i2c_master.start();
    if (p >= 0)
    begin
      xw({dev_addr, 1'b0}, 1'b0);
      xw(8'(p), 1'b0);
      i_tsa_i2c_master.start();
    end
    xw({dev_addr, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      i_tsa_i2c_master.xbyte(8'hff, i == n - 1, q, ack);
      rdv = {rdv[7:0], q};
    end
    i_tsa_i2c_master.stop();
    chk(rdv, e);
  endtask
  task automatic ac(input logic e);
    chk(16'(alarm_oe), 16'(e));
  endtask
  task automatic conv(input logic [8:0] t, input int n);
    repeat (n)
    begin
      conv_temp = t;
      conv_valid = 1'b1;
      tick(1);
      conv_valid = 1'b0;
      tick(2);
    end
  endtask
  task automatic t_regs;
    ac(1'b0);
    rc(-1, 2, 16'h0000);
    rc(1, 1, 16'h0000);
    rc(3, 2, 16'h5000);
    rc(2, 2, 16'h4b00);
    conv(9'h1ff, 1);
    rc(0, 2, 16'hff80);
    wr(0, 2, 16'h1234);
    rc(-1, 2, 16'hff80);
    conv(9'h032, 1);
    rc(-1, 2, 16'h1900);
    wr(3, 2, 16'h5580);
    rc(3, 2, 16'h5580);
    wr(3, 2, 16'h5000);
    wr(1, 2, 16'h08ff);
    rc(1, 2, 16'h0808);
    wr(1, 1, 16'h0000);
  endtask
  task automatic t_bus;
    logic [7:0] q;
    int n;
    rc(0, 2, 16'h1900);
    i_tsa_i2c_master.start();
    xw({dev_addr ^ 7'h01, 1'b0}, 1'b1);
    i_tsa_i2c_master.start();
    xw({dev_addr ^ 7'h40, 1'b0}, 1'b1);
    i_tsa_i2c_master.start();
    xw({dev_addr, 1'b1}, 1'b0);
    i_tsa_i2c_master.xbyte(8'hff, 1'b0, q, ack);
    chk(16'(q), 16'h0019);
    i_tsa_i2c_master.recover(n);
    chk(16'(n <= 9), 16'h0001);
    rc(-1, 2, 16'h1900);
  endtask
  task automatic t_fault;
    int n;
    for (int k = 0; k < 4; k++)
    begin
      n = (k == 0) ? 1 : 2 * k;
      wr(1, 1, {3'h0, 2'(k), 3'h0, 8'h00});
      conv(9'h0a1, n - 1);
      conv(9'h0a0, 1);
      conv(9'h0a1, n - 1);
      ac(1'b0);
      conv(9'h0a1, 1);
      ac(1'b1);
      conv(9'h096, n);
      ac(1'b1);
      conv(9'h095, n);
      ac(1'b0);
    end
  endtask
  task automatic t_int;
    wr(1, 1, 16'h0200);
    conv(9'h0a1, 1);
    ac(1'b1);
    conv(9'h000, 2);
    ac(1'b1);
    rc(-1, 1, 16'h0002);
    ac(1'b0);
    conv(9'h0a1, 1);
    ac(1'b0);
    conv(9'h095, 1);
    ac(1'b1);
    rc(-1, 1, 16'h0002);
    conv(9'h0a1, 1);
    ac(1'b1);
    wr(1, 1, 16'h0300);
    ac(1'b0);
    chk(16'(shutdown_active), 16'h0001);
    tick(12);
    conv(9'h095, 1);
    wr(2, 2, 16'h1080);
    rc(2, 2, 16'h1080);
    rc(1, 1, 16'h0003);
    wr(2, 2, 16'h4b00);
    wr(1, 1, 16'h0400);
    conv(9'h095, 1);
    ac(1'b1);
    conv(9'h0a1, 1);
    ac(1'b0);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard sized well above the expected run length
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      n_errors++;
      results();
    end
  end
  initial
  begin
    reset_n = 1'b0;
    conv_temp = 9'h000;
    conv_valid = 1'b0;
    tick(2);
    reset_n = 1'b1;
    tick(4);
    t_regs();
    t_bus();
    t_fault();
    t_int();
    results();
  end
endmodule
